// *** tlm_pkg.sv ***
// Shared constants and types for the telemetry read-back bank
package tlm_pkg;
  // Command codes
  localparam logic [7:0] CMD_PAGE = 8'h00;
  localparam logic [7:0] CMD_VIN = 8'h88;
  localparam logic [7:0] CMD_IIN = 8'h89;
  localparam logic [7:0] CMD_VOUT = 8'h8b;
  localparam logic [7:0] CMD_IOUT = 8'h8c;
  localparam logic [7:0] CMD_TSTAGE = 8'h8d;
  localparam logic [7:0] CMD_TDIE = 8'h8e;
  localparam logic [7:0] CMD_DUTY = 8'h94;
  localparam logic [7:0] CMD_POUT = 8'h96;
  localparam logic [7:0] CMD_IOUT_PK = 8'hd7;
  localparam logic [7:0] CMD_ADC_SEL = 8'hd8;
  localparam logic [7:0] CMD_FLAGS = 8'hda;
  localparam logic [7:0] CMD_VOUT_PK = 8'hdd;
  localparam logic [7:0] CMD_VIN_PK = 8'hde;
  localparam logic [7:0] CMD_TSTAGE_PK = 8'hdf;
  localparam logic [7:0] CMD_CH_IIN = 8'hed;
  localparam logic [7:0] CMD_TDIE_PK = 8'hf4;
  localparam logic [7:0] CMD_CLEAR_PEAKS = 8'he3;
  // Selection values and reset values
  localparam logic [7:0] SEL_FULL = 8'h00;
  localparam logic [7:0] SEL_SHORT = 8'h0d;
  localparam logic [7:0] ADC_SEL_RESET = 8'h00;
  localparam logic [7:0] PAGE_RESET = 8'h00;
  // Conversion codes handed to the front end
  localparam logic [3:0] CV_VIN = 4'h1;
  localparam logic [3:0] CV_TDIE = 4'h4;
  localparam logic [3:0] CV_V0 = 4'h5;
  localparam logic [3:0] CV_I0 = 4'h6;
  localparam logic [3:0] CV_T0 = 4'h8;
  localparam logic [3:0] CV_V1 = 4'h9;
  localparam logic [3:0] CV_I1 = 4'ha;
  localparam logic [3:0] CV_T1 = 4'hc;
  // Short-loop flag bits
  localparam int FLAG_V0 = 0;
  localparam int FLAG_I0 = 1;
  localparam int FLAG_V1 = 2;
  localparam int FLAG_I1 = 3;
  localparam logic [7:0] FLAG_MASK = 8'h0f;
  // Fixed-point scaling of raw values
  localparam int RAW_FRAC = 4;
  localparam int RAW_BASE_EXP = -4;
  localparam int GAIN_SHIFT = 12;
  localparam int SENSE_SHIFT = 12;
  localparam int TC_SHIFT = 20;
  localparam int TREF_RAW = 400;
  localparam int PCT_RECIP = 655;
  localparam int PCT_SHIFT = 16;
  localparam int L11_MANT_MAX = 1023;
  // Bus byte framing
  localparam logic [3:0] BIT_LAST = 4'h8;
  localparam logic [3:0] BIT_ACK = 4'h9;
  localparam logic [7:0] NO_DATA = 8'hff;
  localparam logic [15:0] NO_WORD = 16'hffff;
  // Bus slave states
  typedef enum logic [5:0] {
    TW_IDLE = 6'h01,
    TW_ADDR = 6'h02,
    TW_CMD = 6'h04,
    TW_WDATA = 6'h08,
    TW_TX = 6'h10,
    TW_SKIP = 6'h20
  } tlm_bus_state_t;
endpackage

// *** tlm_l11_enc.sv ***
// Encoder from raw fixed-point value to exponent/mantissa word
`timescale 1ns/1ps

module tlm_l11_enc #(
  parameter int W = 20,
  parameter int BASE_EXP = -4
) (
  // Raw value in units of two to the base exponent
  input wire logic signed [W-1:0] raw,
  // Encoded word, exponent on top
  output logic [15:0] word
);
  localparam logic signed [W-1:0] MANT_MAX = W'(tlm_pkg::L11_MANT_MAX);
  localparam logic signed [W-1:0] MANT_MIN = ~MANT_MAX;

  logic signed [W-1:0] mant;
  logic [4:0] expo;

  // Shift right until the mantissa fits eleven bits
  always_comb begin
    mant = raw;
    expo = 5'(BASE_EXP);
    for (int i = 0; i < W - 11; i++) begin
      if (mant > MANT_MAX || mant < MANT_MIN) begin
        mant = mant >>> 1;
        expo = expo + 5'h01;
      end
    end
    word = {expo, mant[10:0]};
  end
endmodule

// *** tlm_peak_hold.sv ***
// Peak-hold register with clear
`timescale 1ns/1ps

module tlm_peak_hold #(
  parameter int W = 20,
  parameter bit SIGNED_CMP = 1'b1
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Control
  input wire logic clear,
  input wire logic update,
  input wire logic [W-1:0] value,
  // Held maximum
  output logic [W-1:0] peak
);
  logic held_q;
  logic [W-1:0] peak_q;
  logic above;

  always_comb above = SIGNED_CMP ? ($signed(value) > $signed(peak_q)) : (value > peak_q);

  // A sample in the clear cycle becomes the new maximum
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      held_q <= 1'b0;
      peak_q <= '0;
    end else if (update && (clear || !held_q || above)) begin
      held_q <= 1'b1;
      peak_q <= value;
    end else if (clear) begin
      held_q <= 1'b0;
      peak_q <= '0;
    end
  end

  assign peak = peak_q;
endmodule

// *** tlm_readback_bank.sv ***
// Telemetry read-back bank with its two-wire command port
`timescale 1ns/1ps

// Operation
// - 0x88 returns input voltage, 11-bit linear
// - 0x8B returns paged output voltage, unsigned
// - 0x89 returns sum of channel input currents
// - 0xED returns offset plus current times duty
// - 0x8C returns calibrated paged output current
// - 0x8D stage temperature, used for calibration
// - 0x8E die temperature, affects nothing else
// - 0x94 returns paged duty cycle
// - 0x96 power from correlated voltage, current
// - 0xDD paged output voltage peak
// - 0xDE input voltage peak
// - 0xDF paged stage temperature peak
// - 0xF4 die temperature peak
// - 0xD7 paged output current peak
// - 0xD8 selection byte, resets to zero
// - 0xDA flags each short-loop conversion until cleared
// - Full, short, single or reserved loop
// - Flag bits per channel, cleared by ones
module tlm_readback_bank #(
  parameter logic [6:0] DEV_ADDR = 7'h4f,
  parameter int RAW_W = 20
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Two-wire bus pins
  input wire logic scl,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  // Front end samples
  input wire logic sampleValid,
  input wire logic [15:0] sampleData,
  output logic [3:0] convSel,
  output logic invalidData,
  // Controller settings per channel, output voltage exponent shared by both
  input wire logic [15:0] dutyCycle [2],
  input wire logic [15:0] inputCurrentOffset [2],
  input wire logic [15:0] currentSenseGain [2],
  input wire logic [15:0] currentGainTempCoeff [2],
  input wire logic [15:0] stageTempGain [2],
  input wire logic [15:0] stageTempOffset [2],
  input wire logic [4:0] outputVoltageExp
);
  localparam int NPK = 8;
  localparam logic [3:0] PK_SEL [NPK] = '{tlm_pkg::CV_VIN, tlm_pkg::CV_TDIE, tlm_pkg::CV_I0,
    tlm_pkg::CV_I1, tlm_pkg::CV_T0, tlm_pkg::CV_T1, tlm_pkg::CV_V0, tlm_pkg::CV_V1};

  logic sclS1_q, sclS2_q, sclS3_q;
  logic sdaS1_q, sdaS2_q, sdaS3_q;
  logic sclRise, sclFall, startCond, stopCond;
  tlm_pkg::tlm_bus_state_t state_q;
  logic [3:0] bitCnt_q;
  logic [7:0] rxShift_q, txShift_q, cmd_q, page_q, adcSelect_q, flags_q;
  logic [15:0] txWord_q;
  logic [1:0] txIdx_q;
  logic readReq_q, dataSeen_q, sdaOe_q, sdaOut_q;
  logic byteDone, addrHit, cmdByte, wrByte, clearPeaks;
  logic [7:0] txNext, flagSet, flagClr, adcSelNext;
  logic [3:0] convSel_q, lastSel_q;
  logic invalidData_q, sampleDone_q;
  logic pg, sampleCh;
  logic [15:0] vout_q [2];
  logic signed [RAW_W-1:0] vin_q, tDie_q;
  logic signed [RAW_W-1:0] iout_q [2];
  logic signed [RAW_W-1:0] tStage_q [2];
  logic signed [RAW_W-1:0] pout_q [2];
  logic signed [RAW_W-1:0] chIin [2];
  logic signed [RAW_W-1:0] sampleExt, tStageNew, ioutNew, poutNew, totalIin, respRaw;
  logic signed [31:0] tProd, iBase, dT;
  logic signed [63:0] iAdj, pProd;
  logic signed [63:0] iinProd [2];
  logic [4:0] pShift;
  logic [RAW_W-1:0] pkVal [NPK];
  logic [RAW_W-1:0] pkOut [NPK];
  logic [15:0] respWord, l11Word;
  logic useL11;

  // Two-flop synchronisers, third stage keeps history for edges
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      sclS1_q <= 1'b1;
      sclS2_q <= 1'b1;
      sclS3_q <= 1'b1;
      sdaS1_q <= 1'b1;
      sdaS2_q <= 1'b1;
      sdaS3_q <= 1'b1;
    end else begin
      sclS1_q <= scl;
      sclS2_q <= sclS1_q;
      sclS3_q <= sclS2_q;
      sdaS1_q <= sdaIn;
      sdaS2_q <= sdaS1_q;
      sdaS3_q <= sdaS2_q;
    end
  end

  always_comb begin
    sclRise = sclS2_q & ~sclS3_q;
    sclFall = ~sclS2_q & sclS3_q;
    startCond = sclS2_q & sclS3_q & ~sdaS2_q & sdaS3_q;
    stopCond = sclS2_q & sclS3_q & sdaS2_q & ~sdaS3_q;
    byteDone = sclFall && bitCnt_q == tlm_pkg::BIT_LAST;
    addrHit = rxShift_q[7:1] == DEV_ADDR;
    cmdByte = byteDone && state_q == tlm_pkg::TW_CMD;
    wrByte = byteDone && state_q == tlm_pkg::TW_WDATA && !dataSeen_q;
    clearPeaks = cmdByte && rxShift_q == tlm_pkg::CMD_CLEAR_PEAKS;
    unique case (txIdx_q)
      2'h0: txNext = txWord_q[7:0];
      2'h1: txNext = txWord_q[15:8];
      default: txNext = tlm_pkg::NO_DATA;
    endcase
  end

  // Bus slave: framing, acknowledge and transmit
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= tlm_pkg::TW_IDLE;
      bitCnt_q <= '0;
      rxShift_q <= '0;
      txShift_q <= '0;
      txWord_q <= '0;
      txIdx_q <= '0;
      readReq_q <= 1'b0;
      sdaOe_q <= 1'b0;
    end else if (stopCond) begin
      state_q <= tlm_pkg::TW_IDLE;
      sdaOe_q <= 1'b0;
    end else if (startCond) begin
      state_q <= tlm_pkg::TW_ADDR;
      bitCnt_q <= '0;
      sdaOe_q <= 1'b0;
    end else if (sclRise) begin
      if (bitCnt_q < tlm_pkg::BIT_LAST) begin
        rxShift_q <= {rxShift_q[6:0], sdaS2_q};
        bitCnt_q <= bitCnt_q + 4'h1;
      end else if (state_q == tlm_pkg::TW_TX && bitCnt_q == tlm_pkg::BIT_LAST) begin
        bitCnt_q <= tlm_pkg::BIT_ACK;
        if (sdaS2_q) begin
          state_q <= tlm_pkg::TW_SKIP;
        end
      end
    end else if (sclFall) begin
      unique case (state_q)
        tlm_pkg::TW_ADDR: begin
          if (bitCnt_q == tlm_pkg::BIT_LAST) begin
            bitCnt_q <= tlm_pkg::BIT_ACK;
            sdaOe_q <= addrHit;
            readReq_q <= rxShift_q[0];
            txWord_q <= respWord;
            txIdx_q <= '0;
            if (!addrHit) begin
              state_q <= tlm_pkg::TW_SKIP;
            end
          end else if (bitCnt_q == tlm_pkg::BIT_ACK) begin
            bitCnt_q <= '0;
            if (readReq_q) begin
              state_q <= tlm_pkg::TW_TX;
              txShift_q <= txNext;
              sdaOe_q <= ~txNext[7];
              txIdx_q <= txIdx_q + 2'h1;
            end else begin
              state_q <= tlm_pkg::TW_CMD;
              sdaOe_q <= 1'b0;
            end
          end
        end
        tlm_pkg::TW_CMD, tlm_pkg::TW_WDATA: begin
          if (bitCnt_q == tlm_pkg::BIT_LAST) begin
            bitCnt_q <= tlm_pkg::BIT_ACK;
            sdaOe_q <= 1'b1;
          end else if (bitCnt_q == tlm_pkg::BIT_ACK) begin
            bitCnt_q <= '0;
            sdaOe_q <= 1'b0;
            state_q <= tlm_pkg::TW_WDATA;
          end
        end
        tlm_pkg::TW_TX: begin
          if (bitCnt_q < tlm_pkg::BIT_LAST) begin
            sdaOe_q <= ~txShift_q[3'(4'h7 - bitCnt_q)];
          end else if (bitCnt_q == tlm_pkg::BIT_LAST) begin
            sdaOe_q <= 1'b0;
          end else begin
            bitCnt_q <= '0;
            txShift_q <= txNext;
            sdaOe_q <= ~txNext[7];
            if (txIdx_q != 2'h2) begin
              txIdx_q <= txIdx_q + 2'h1;
            end
          end
        end
        default: begin
          sdaOe_q <= 1'b0;
        end
      endcase
    end
  end

  // Data pin only ever pulls low
  always_ff @(posedge sys_clk) begin
    sdaOut_q <= 1'b0;
  end

  // Command byte and writable registers
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cmd_q <= '0;
      dataSeen_q <= 1'b0;
      page_q <= tlm_pkg::PAGE_RESET;
      adcSelect_q <= tlm_pkg::ADC_SEL_RESET;
    end else begin
      if (cmdByte) begin
        cmd_q <= rxShift_q;
        dataSeen_q <= 1'b0;
      end else if (wrByte) begin
        dataSeen_q <= 1'b1;
      end
      if (wrByte && cmd_q == tlm_pkg::CMD_PAGE) begin
        page_q <= rxShift_q;
      end
      if (wrByte && cmd_q == tlm_pkg::CMD_ADC_SEL) begin
        adcSelect_q <= rxShift_q;
      end
    end
  end

  // Short-loop flags: a conversion in the clear cycle survives
  always_comb begin
    flagSet = '0;
    if (sampleValid && adcSelect_q == tlm_pkg::SEL_SHORT) begin
      flagSet[tlm_pkg::FLAG_V0] = convSel_q == tlm_pkg::CV_V0;
      flagSet[tlm_pkg::FLAG_I0] = convSel_q == tlm_pkg::CV_I0;
      flagSet[tlm_pkg::FLAG_V1] = convSel_q == tlm_pkg::CV_V1;
      flagSet[tlm_pkg::FLAG_I1] = convSel_q == tlm_pkg::CV_I1;
    end
    flagClr = (wrByte && cmd_q == tlm_pkg::CMD_FLAGS) ? rxShift_q : '0;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      flags_q <= '0;
    end else begin
      flags_q <= ((flags_q & ~flagClr) | flagSet) & tlm_pkg::FLAG_MASK;
    end
  end

  // Next conversion for the selected loop
  function automatic logic [3:0] nextConv(input logic [7:0] mode, input logic [3:0] cur);
    logic [3:0] nxt;
    nxt = tlm_pkg::CV_TDIE;
    if (mode == tlm_pkg::SEL_FULL) begin
      case (cur)
        tlm_pkg::CV_VIN: nxt = tlm_pkg::CV_TDIE;
        tlm_pkg::CV_TDIE: nxt = tlm_pkg::CV_V0;
        tlm_pkg::CV_V0: nxt = tlm_pkg::CV_I0;
        tlm_pkg::CV_I0: nxt = tlm_pkg::CV_T0;
        tlm_pkg::CV_T0: nxt = tlm_pkg::CV_V1;
        tlm_pkg::CV_V1: nxt = tlm_pkg::CV_I1;
        tlm_pkg::CV_I1: nxt = tlm_pkg::CV_T1;
        default: nxt = tlm_pkg::CV_VIN;
      endcase
    end else if (mode == tlm_pkg::SEL_SHORT) begin
      case (cur)
        tlm_pkg::CV_V0: nxt = tlm_pkg::CV_I0;
        tlm_pkg::CV_I0: nxt = tlm_pkg::CV_V1;
        tlm_pkg::CV_V1: nxt = tlm_pkg::CV_I1;
        default: nxt = tlm_pkg::CV_V0;
      endcase
    end else if (mode[7:4] == 4'h0 && mode[3:0] inside {tlm_pkg::CV_VIN, tlm_pkg::CV_V0,
        tlm_pkg::CV_I0, tlm_pkg::CV_T0, tlm_pkg::CV_V1, tlm_pkg::CV_I1, tlm_pkg::CV_T1}) begin
      nxt = mode[3:0];
    end
    return nxt;
  endfunction

  // Selection after this edge, so the invalid status moves with the selection
  always_comb begin
    adcSelNext = (wrByte && cmd_q == tlm_pkg::CMD_ADC_SEL) ? rxShift_q : adcSelect_q;
  end

  // Conversion sequencing and invalid selection status
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      convSel_q <= tlm_pkg::CV_VIN;
      invalidData_q <= 1'b0;
      sampleDone_q <= 1'b0;
      lastSel_q <= '0;
    end else begin
      if (sampleValid) begin
        convSel_q <= nextConv(adcSelect_q, convSel_q);
      end
      invalidData_q <= (adcSelNext[7:4] != 4'h0) || (adcSelNext != tlm_pkg::SEL_SHORT
        && adcSelNext != tlm_pkg::SEL_FULL && nextConv(adcSelNext, convSel_q) == tlm_pkg::CV_TDIE
        && adcSelNext[3:0] != tlm_pkg::CV_TDIE);
      sampleDone_q <= sampleValid;
      lastSel_q <= convSel_q;
    end
  end

  // Calibration arithmetic on the incoming sample
  always_comb begin
    sampleCh = convSel_q inside {tlm_pkg::CV_V1, tlm_pkg::CV_I1, tlm_pkg::CV_T1};
    sampleExt = RAW_W'($signed(sampleData));
    tProd = $signed(sampleData) * $signed(stageTempGain[sampleCh]);
    tStageNew = RAW_W'((tProd >>> tlm_pkg::GAIN_SHIFT) + $signed(stageTempOffset[sampleCh]));
    iBase = ($signed(sampleData) * $signed(currentSenseGain[sampleCh])) >>> tlm_pkg::SENSE_SHIFT;
    dT = tStage_q[sampleCh] - tlm_pkg::TREF_RAW;
    iAdj = iBase * $signed(currentGainTempCoeff[sampleCh]) * dT;
    ioutNew = RAW_W'(iBase + 32'(iAdj >>> tlm_pkg::TC_SHIFT));
    pShift = outputVoltageExp[4] ? (~outputVoltageExp + 5'h01) : 5'h00;
    pProd = $signed({1'b0, vout_q[sampleCh]}) * ioutNew;
    poutNew = RAW_W'(pProd >>> pShift);
    for (int c = 0; c < 2; c++) begin
      iinProd[c] = iout_q[c] * $signed(dutyCycle[c]) * tlm_pkg::PCT_RECIP;
      chIin[c] = RAW_W'($signed(inputCurrentOffset[c])
        + 32'(iinProd[c] >>> (tlm_pkg::PCT_SHIFT + tlm_pkg::RAW_FRAC)));
    end
    totalIin = chIin[0] + chIin[1];
  end

  // Latest readings
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      vin_q <= '0;
      tDie_q <= '0;
      vout_q <= '{default: '0};
      iout_q <= '{default: '0};
      tStage_q <= '{default: '0};
      pout_q <= '{default: '0};
    end else if (sampleValid) begin
      case (convSel_q)
        tlm_pkg::CV_VIN: vin_q <= sampleExt;
        tlm_pkg::CV_TDIE: tDie_q <= sampleExt;
        tlm_pkg::CV_V0, tlm_pkg::CV_V1: vout_q[sampleCh] <= sampleData;
        tlm_pkg::CV_I0, tlm_pkg::CV_I1: begin
          iout_q[sampleCh] <= ioutNew;
          pout_q[sampleCh] <= poutNew;
        end
        tlm_pkg::CV_T0, tlm_pkg::CV_T1: tStage_q[sampleCh] <= tStageNew;
        default: begin
        end
      endcase
    end
  end

  // Peak holds, updated the cycle after each reading lands
  always_comb begin
    pkVal[0] = vin_q;
    pkVal[1] = tDie_q;
    pkVal[2] = iout_q[0];
    pkVal[3] = iout_q[1];
    pkVal[4] = tStage_q[0];
    pkVal[5] = tStage_q[1];
    pkVal[6] = RAW_W'(vout_q[0]);
    pkVal[7] = RAW_W'(vout_q[1]);
  end

  for (genvar i = 0; i < NPK; i++) begin : gPeak
    tlm_peak_hold #(
      .W(RAW_W),
      .SIGNED_CMP(i < 6)
    ) uPeak (
      .sys_clk(sys_clk),
      .srst(srst),
      .clear(clearPeaks),
      .update(sampleDone_q && lastSel_q == PK_SEL[i]),
      .value(pkVal[i]),
      .peak(pkOut[i])
    );
  end

  // Response word for the current command and page
  always_comb begin
    pg = page_q[0];
    respRaw = '0;
    respWord = tlm_pkg::NO_WORD;
    useL11 = 1'b1;
    case (cmd_q)
      tlm_pkg::CMD_VIN: respRaw = vin_q;
      tlm_pkg::CMD_IIN: respRaw = totalIin;
      tlm_pkg::CMD_CH_IIN: respRaw = chIin[pg];
      tlm_pkg::CMD_IOUT: respRaw = iout_q[pg];
      tlm_pkg::CMD_TSTAGE: respRaw = tStage_q[pg];
      tlm_pkg::CMD_TDIE: respRaw = tDie_q;
      tlm_pkg::CMD_DUTY: respRaw = RAW_W'($signed(dutyCycle[pg]));
      tlm_pkg::CMD_POUT: respRaw = pout_q[pg];
      tlm_pkg::CMD_VIN_PK: respRaw = pkOut[0];
      tlm_pkg::CMD_TDIE_PK: respRaw = pkOut[1];
      tlm_pkg::CMD_IOUT_PK: respRaw = pkOut[2 + 32'(pg)];
      tlm_pkg::CMD_TSTAGE_PK: respRaw = pkOut[4 + 32'(pg)];
      tlm_pkg::CMD_VOUT: begin
        useL11 = 1'b0;
        respWord = vout_q[pg];
      end
      tlm_pkg::CMD_VOUT_PK: begin
        useL11 = 1'b0;
        respWord = pkOut[6 + 32'(pg)][15:0];
      end
      tlm_pkg::CMD_ADC_SEL: begin
        useL11 = 1'b0;
        respWord = {tlm_pkg::NO_DATA, adcSelect_q};
      end
      tlm_pkg::CMD_FLAGS: begin
        useL11 = 1'b0;
        respWord = {tlm_pkg::NO_DATA, flags_q};
      end
      tlm_pkg::CMD_PAGE: begin
        useL11 = 1'b0;
        respWord = {tlm_pkg::NO_DATA, page_q};
      end
      default: useL11 = 1'b0;
    endcase
    if (useL11) begin
      respWord = l11Word;
    end
  end

  tlm_l11_enc #(
    .W(RAW_W),
    .BASE_EXP(tlm_pkg::RAW_BASE_EXP)
  ) uEnc (
    .raw(respRaw),
    .word(l11Word)
  );

  assign sdaOut = sdaOut_q;
  assign sdaOe = sdaOe_q;
  assign convSel = convSel_q;
  assign invalidData = invalidData_q;
endmodule

// *** tlm_bank_checker.sv ***
// Port assertions for the telemetry read-back bank
`timescale 1ns/1ps
module tlm_bank_checker (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Watched ports
  input wire logic scl,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic sampleValid,
  input wire logic [3:0] convSel,
  input wire logic invalidData
);
  default clocking cb @(posedge sys_clk);
  endclocking
  chk_reset_idle: assert property (srst |=> convSel == tlm_pkg::CV_VIN && !sdaOe && !invalidData)
    else $error("outputs not idle after reset");
  chk_conv_holds: assert property (disable iff (srst) !sampleValid |=> $stable(convSel))
    else $error("conversion code moved without a sample");
  chk_reserved_die: assert property (disable iff (srst) invalidData && sampleValid |=> convSel == tlm_pkg::CV_TDIE)
    else $error("reserved selection not on die temperature");
  chk_conv_legal: assert property (disable iff (srst) convSel inside {4'h1, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha, 4'hc})
    else $error("conversion code not a valid parameter");
  chk_oe_rise_low: assert property (disable iff (srst) $rose(sdaOe) |-> !scl && !$past(scl, 2))
    else $error("data pulled low outside bus clock low");
  chk_oe_fall_low: assert property (disable iff (srst) $fell(sdaOe) |-> !scl && !$past(scl, 2))
    else $error("data released outside bus clock low");
  chk_oe_steady_high: assert property (disable iff (srst) scl && $past(scl) |-> $stable(sdaOe))
    else $error("data changed while bus clock high");
  chk_drive_zero: assert property (disable iff (srst) sdaOut == 1'b0)
    else $error("data drive value not zero");
endmodule

bind tlm_readback_bank tlm_bank_checker u_tlm_bank_checker (
  .sys_clk(sys_clk), .srst(srst), .scl(scl), .sdaOut(sdaOut), .sdaOe(sdaOe),
  .sampleValid(sampleValid), .convSel(convSel), .invalidData(invalidData)
);

// *** tlm_host_model.sv ***
// Bus host model for the two-wire command port
`timescale 1ns/1ps
module tlm_host_model #(
  parameter logic [6:0] ADDR = 7'h4f
) (
  // Clock
  input wire logic sys_clk,
  // Wire
  input wire logic sdaOe,
  output logic scl,
  output logic sdaIn
);
  logic pullLow = 1'b0;
  initial scl = 1'b1;
  // Open-drain data wire with pull-up
  assign sdaIn = !(pullLow || sdaOe);
  task automatic tick(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic start();
    if (!scl) begin
      tick(2);
      pullLow = 1'b0;
      tick(2);
      scl = 1'b1;
    end
    tick(4);
    pullLow = 1'b1;
    tick(4);
    scl = 1'b0;
  endtask
  task automatic stop();
    tick(2);
    pullLow = 1'b1;
    tick(2);
    scl = 1'b1;
    tick(4);
    pullLow = 1'b0;
    tick(4);
  endtask
  task automatic bit_io(input logic b, output logic r);
    tick(2);
    pullLow = !b;
    tick(2);
    scl = 1'b1;
    tick(3);
    r = sdaIn;
    tick(1);
    scl = 1'b0;
  endtask
  task automatic put(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask
  task automatic get(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      b[i] = r;
    end
    bit_io(last, r);
  endtask
  // Byte write, or send byte when withData is low
  task automatic write_cmd(input logic [7:0] c, input logic [7:0] d, input logic withData, output logic ok);
    logic a0, a1, a2;
    a2 = 1'b1;
    start();
    put({ADDR, 1'b0}, a0);
    put(c, a1);
    if (withData) put(d, a2);
    stop();
    ok = a0 & a1 & a2;
  endtask
  // Word read, low byte first, nack on the last byte
  task automatic read_word(input logic [7:0] c, output logic [15:0] w, output logic ok);
    logic a0, a1, a2;
    start();
    put({ADDR, 1'b0}, a0);
    put(c, a1);
    start();
    put({ADDR, 1'b1}, a2);
    get(1'b0, w[7:0]);
    get(1'b1, w[15:8]);
    stop();
    ok = a0 & a1 & a2;
  endtask
endmodule

// *** tb_top.sv ***
// Self-checking bench for the telemetry read-back bank
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  logic scl, sdaIn, sdaOut, sdaOe, invalidData;
  logic sampleValid = 1'b0;
  logic [15:0] sampleData = 16'h0000;
  logic [3:0] convSel;
  logic [15:0] dutyCycle [2] = '{16'h0320, 16'h0640};
  logic [15:0] iinOffset [2] = '{16'h0010, 16'h0020};
  logic [15:0] senseGain [2] = '{16'h1000, 16'h1000};
  logic [15:0] gainTc [2] = '{16'h0000, 16'h0000};
  logic [15:0] tempGain [2] = '{16'h1000, 16'h1000};
  logic [15:0] tempOffset [2] = '{16'h0000, 16'h0000};
  logic [4:0] voutExp = 5'h14;
  logic [3:0] codes [4] = '{4'h5, 4'h6, 4'h9, 4'ha};
  logic [15:0] vals [4] = '{16'h0300, 16'h0020, 16'h0500, 16'h0030};
  int failCount = 0;
  int checked = 0;
  int cycles = 0;
  always #25 sys_clk = ~sys_clk;
  tlm_readback_bank u_tlm_readback_bank (
    .sys_clk(sys_clk), .srst(srst), .scl(scl), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .sampleValid(sampleValid), .sampleData(sampleData), .convSel(convSel), .invalidData(invalidData),
    .dutyCycle(dutyCycle), .inputCurrentOffset(iinOffset), .currentSenseGain(senseGain),
    .currentGainTempCoeff(gainTc), .stageTempGain(tempGain), .stageTempOffset(tempOffset),
    .outputVoltageExp(voutExp)
  );
  tlm_host_model u_tlm_host_model (.sys_clk(sys_clk), .sdaOe(sdaOe), .scl(scl), .sdaIn(sdaIn));
  task automatic report_and_stop();
    if (failCount == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failCount++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [15:0] e);
    logic [15:0] w;
    logic a;
    u_tlm_host_model.read_word(c, w, a);
    check({15'h0000, a}, 16'h0001);
    check(w, e);
  endtask
  task automatic wr(input logic [7:0] c, input logic [7:0] d, input logic n);
    logic a;
    u_tlm_host_model.write_cmd(c, d, n, a);
    check({15'h0000, a}, 16'h0001);
  endtask
  task automatic feed(input logic [15:0] d);
    @(negedge sys_clk);
    sampleValid = 1'b1;
    sampleData = d;
    @(negedge sys_clk);
    sampleValid = 1'b0;
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      failCount++;
      report_and_stop();
    end
  end
  initial begin
    repeat (16) @(negedge sys_clk);
    srst = 1'b0;
    repeat (4) @(negedge sys_clk);
    check({12'h000, convSel}, 16'h0001);
    rd(tlm_pkg::CMD_ADC_SEL, 16'hff00);
    rd(tlm_pkg::CMD_FLAGS, 16'hff00);
    wr(tlm_pkg::CMD_ADC_SEL, tlm_pkg::SEL_SHORT, 1'b1);
    feed(16'h0000);
    for (int i = 0; i < 4; i++) begin
      check({12'h000, convSel}, {12'h000, codes[i]});
      feed(vals[i]);
    end
    rd(tlm_pkg::CMD_FLAGS, 16'hff0f);
    wr(tlm_pkg::CMD_FLAGS, 8'h03, 1'b1);
    rd(tlm_pkg::CMD_FLAGS, 16'hff0c);
    wr(tlm_pkg::CMD_PAGE, 8'h01, 1'b1);
    rd(tlm_pkg::CMD_VOUT, 16'h0500);
    rd(tlm_pkg::CMD_VOUT_PK, 16'h0500);
    check({12'h000, convSel}, 16'h0005);
    feed(16'h0100);
    wr(tlm_pkg::CMD_PAGE, 8'h00, 1'b1);
    rd(tlm_pkg::CMD_VOUT, 16'h0100);
    rd(tlm_pkg::CMD_VOUT_PK, 16'h0300);
    wr(tlm_pkg::CMD_CLEAR_PEAKS, 8'h00, 1'b0);
    rd(tlm_pkg::CMD_VOUT_PK, 16'h0000);
    for (int i = 1; i < 4; i++) feed(vals[i]);
    feed(16'h0080);
    rd(tlm_pkg::CMD_VOUT_PK, 16'h0080);
    rd(8'h8a, 16'hffff);
    wr(tlm_pkg::CMD_ADC_SEL, 8'h01, 1'b1);
    feed(16'h0000);
    check({12'h000, convSel}, 16'h0001);
    feed(16'h0100);
    rd(tlm_pkg::CMD_VIN, 16'he100);
    rd(tlm_pkg::CMD_VIN_PK, 16'he100);
    wr(tlm_pkg::CMD_VIN, 8'h55, 1'b1);
    rd(tlm_pkg::CMD_VIN, 16'he100);
    wr(tlm_pkg::CMD_ADC_SEL, 8'h04, 1'b1);
    feed(16'h0000);
    check({12'h000, convSel}, 16'h0004);
    feed(16'h0190);
    rd(tlm_pkg::CMD_TDIE, 16'he190);
    rd(tlm_pkg::CMD_TDIE_PK, 16'he190);
    wr(tlm_pkg::CMD_ADC_SEL, 8'h07, 1'b1);
    check({15'h0000, invalidData}, 16'h0001);
    feed(16'h0000);
    check({12'h000, convSel}, 16'h0004);
    rd(tlm_pkg::CMD_ADC_SEL, 16'hff07);
    wr(tlm_pkg::CMD_ADC_SEL, 8'h08, 1'b1);
    feed(16'h0000);
    check({12'h000, convSel}, 16'h0008);
    check({15'h0000, invalidData}, 16'h0000);
    feed(16'h0190);
    rd(tlm_pkg::CMD_TSTAGE, 16'he190);
    rd(tlm_pkg::CMD_TSTAGE_PK, 16'he190);
    rd(tlm_pkg::CMD_IOUT_PK, 16'he020);
    rd(tlm_pkg::CMD_IIN, 16'he05f);
    wr(tlm_pkg::CMD_PAGE, 8'h01, 1'b1);
    rd(tlm_pkg::CMD_IOUT, 16'he030);
    rd(tlm_pkg::CMD_POUT, 16'he00f);
    rd(tlm_pkg::CMD_DUTY, 16'heb20);
    rd(tlm_pkg::CMD_CH_IIN, 16'he04f);
    report_and_stop();
  end
endmodule
